// ### sutr_consts.svh
// Register offsets, field positions, reset values and codes of the
// miscellaneous register group. Included by the generator, register group, checker and bench files.
`ifndef SUTR_CONSTS_SVH
`define SUTR_CONSTS_SVH

`define SUTR_ADDR_W 8
`define SUTR_OFS_SCRATCH 8'h78
`define SUTR_OFS_UNLOCK 8'h7C
`define SUTR_OFS_TEST 8'h84
`define SUTR_OFS_STATUS 8'h88
`define SUTR_UNLOCK_KEY 16'hAA37
`define SUTR_SCRATCH_RST 16'h0000
`define SUTR_TEST_RST 8'h00
`define SUTR_TEST_MASK 8'h9F
`define SUTR_BIT_FORCE_FAST 7
`define SUTR_BIT_FORCE_FULL 4
`define SUTR_BIT_PSEUDO_RANDOM_LINE_TEST 3
`define SUTR_BIT_K 2
`define SUTR_BIT_J 1
`define SUTR_BIT_QNAK 0
`define SUTR_LFSR_SEED 9'h1FF

`endif

// ### sutr_pkg.sv
// Types shared by the register group and its line pattern generator.
// Assumes sutr_consts.svh is on the include path.
package sutr_pkg;
    typedef enum logic [2:0] {
        SUTR_LINE_NORMAL,
        SUTR_LINE_J,
        SUTR_LINE_K,
        SUTR_LINE_QUIET,
        SUTR_LINE_PSEUDO_RANDOM_LINE_TEST
    } sutr_line_t;
endpackage : sutr_pkg

// ### sutr_line_if.sv
// Carries the line test request and pattern bits between the register
// group and its pattern generator. Same clock on both sides.
`timescale 1ns/100ps
interface sutr_line_if;
    logic pseudo_random_line_test_run;
    logic pseudo_random_line_test_bit;
    modport regs (output pseudo_random_line_test_run, input pseudo_random_line_test_bit);
    modport gen (input pseudo_random_line_test_run, output pseudo_random_line_test_bit);
endinterface : sutr_line_if

// ### sutr_pseudo_random_line_test_gen.sv
// Pseudo-random line pattern source for the pattern test mode.
// Runs on ref_clk; advances one step per cycle while requested.
`timescale 1ns/100ps
`include "sutr_consts.svh"
module sutr_pseudo_random_line_test_gen (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link to register group
    sutr_line_if.gen line
);
    import sutr_pkg::*;

    logic [8:0] lfsr_reg;

    // Fixed seed, so the pattern repeats identically every run
    always_ff @(posedge ref_clk)
    begin
        if (rst || !line.pseudo_random_line_test_run)
            lfsr_reg <= `SUTR_LFSR_SEED;
        else
            lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
    end

    assign line.pseudo_random_line_test_bit = lfsr_reg[8];
endmodule : sutr_pseudo_random_line_test_gen

// ### sutr_regs.sv
// Scratch store, write lock with unlock key, and line test control.
// Assumes a firmware register port on ref_clk and suspend/resume and
// processor-powered levels already synchronous to ref_clk.
`timescale 1ns/100ps
`include "sutr_consts.svh"

// Overview of operation
// - 16-bit scratch store, upper byte 15:8, lower byte 7:0.
// - Powered flag low: suspend locks all register writes except the key write at 7Ch.
// - Only key AA37h written at 7Ch releases the write lock.
// - Powered flag high: suspend never locks, no key needed.
// - One-byte line test register at 84h.
// - Bit 7: high-speed only, chirp detection off.
// - Bit 4: full-speed only, chirp detection off.
// - Bit 3: lines toggle in fixed pseudo-random pattern.
// - Bit 2 drives K state, bit 1 drives J state.
// - Bit 0: quiescent lines, NAK every high-speed IN token.
// - Test mode entered stays until power cycle.
module sutr_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [`SUTR_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Power state
    input wire logic processor_powered_flag,
    input wire logic suspend_active,
    // Write permission for other registers and FIFOs
    output logic write_enable,
    // Line control toward the transceiver
    output sutr_pkg::sutr_line_t line_mode,
    output logic line_dp,
    output logic line_dm,
    output logic force_fast_only,
    output logic force_full_only,
    output logic chirp_detect_en,
    output logic in_nak_only
);
    import sutr_pkg::*;

    sutr_line_if line ();

    sutr_pseudo_random_line_test_gen u_pseudo_random_line_test (
        .ref_clk(ref_clk),
        .rst(rst),
        .line(line)
    );

    logic [7:0] scratch_upper_byte;
    logic [7:0] scratch_lower_byte;
    logic [7:0] test_reg;
    logic [7:0] test_sticky_reg;
    logic lock_reg;
    logic suspend_reg;
    logic [15:0] rdata_reg;
    logic wr_ok;
    logic key_hit;
    // Full-width copy so each byte takes its own slice of the reset value
    localparam logic [15:0] SCRATCH_RST = `SUTR_SCRATCH_RST;

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction : addr_is

    assign key_hit = reg_wr && addr_is(reg_addr, `SUTR_OFS_UNLOCK)
        && (reg_wdata == `SUTR_UNLOCK_KEY);
    // Key write passes unless a suspend entry locks in the same cycle; all others wait for unlock
    assign wr_ok = reg_wr && !lock_reg;
    assign write_enable = !lock_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            suspend_reg <= 1'b0;
        else
            suspend_reg <= suspend_active;
    end

    // Lock on entering suspend with powered flag low; set wins over unlock in same cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            lock_reg <= 1'b0;
        else if (suspend_active && !suspend_reg && !processor_powered_flag)
            lock_reg <= 1'b1;
        else if (key_hit)
            lock_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            scratch_upper_byte <= SCRATCH_RST[15:8];
            scratch_lower_byte <= SCRATCH_RST[7:0];
        end
        else if (wr_ok && addr_is(reg_addr, `SUTR_OFS_SCRATCH))
        begin
            scratch_upper_byte <= reg_wdata[15:8];
            scratch_lower_byte <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            test_reg <= `SUTR_TEST_RST;
        else if (wr_ok && addr_is(reg_addr, `SUTR_OFS_TEST))
            test_reg <= reg_wdata[7:0] & `SUTR_TEST_MASK;
    end

    // Only a power cycle (rst) leaves test mode; clearing bits does not
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            test_sticky_reg <= `SUTR_TEST_RST;
        else
            test_sticky_reg <= test_sticky_reg | test_reg;
    end

    // Read data stand for exactly the cycle after the read strobe
    always_ff @(posedge ref_clk)
    begin
        if (rst || !reg_rd)
            rdata_reg <= 16'h0000;
        else if (addr_is(reg_addr, `SUTR_OFS_SCRATCH))
            rdata_reg <= {scratch_upper_byte, scratch_lower_byte};
        else if (addr_is(reg_addr, `SUTR_OFS_TEST))
            rdata_reg <= {8'h00, test_reg};
        else if (addr_is(reg_addr, `SUTR_OFS_STATUS))
            rdata_reg <= {15'h0000, lock_reg};
        else
            rdata_reg <= 16'h0000;
    end
    assign reg_rdata = rdata_reg;

    assign line.pseudo_random_line_test_run = test_sticky_reg[`SUTR_BIT_PSEUDO_RANDOM_LINE_TEST];

    // Line mode; priority only matters if firmware breaks one-bit use
    always_comb
    begin
        if (test_sticky_reg[`SUTR_BIT_PSEUDO_RANDOM_LINE_TEST])
            line_mode = SUTR_LINE_PSEUDO_RANDOM_LINE_TEST;
        else if (test_sticky_reg[`SUTR_BIT_K])
            line_mode = SUTR_LINE_K;
        else if (test_sticky_reg[`SUTR_BIT_J])
            line_mode = SUTR_LINE_J;
        else if (test_sticky_reg[`SUTR_BIT_QNAK])
            line_mode = SUTR_LINE_QUIET;
        else
            line_mode = SUTR_LINE_NORMAL;
    end

    // Line levels registered; J = DP high, K = DM high
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            line_dp <= 1'b0;
            line_dm <= 1'b0;
        end
        else
        begin
            case (line_mode)
                SUTR_LINE_J:
                begin
                    line_dp <= 1'b1;
                    line_dm <= 1'b0;
                end
                SUTR_LINE_K:
                begin
                    line_dp <= 1'b0;
                    line_dm <= 1'b1;
                end
                SUTR_LINE_PSEUDO_RANDOM_LINE_TEST:
                begin
                    line_dp <= line.pseudo_random_line_test_bit;
                    line_dm <= !line.pseudo_random_line_test_bit;
                end
                default:
                begin
                    line_dp <= 1'b0;
                    line_dm <= 1'b0;
                end
            endcase
        end
    end

    assign force_fast_only = test_sticky_reg[`SUTR_BIT_FORCE_FAST];
    assign force_full_only = test_sticky_reg[`SUTR_BIT_FORCE_FULL];
    assign chirp_detect_en = !(force_fast_only || force_full_only);
    assign in_nak_only = test_sticky_reg[`SUTR_BIT_QNAK];
endmodule : sutr_regs

// ### sutr_regs_asserts.sv
// Port checker for the register group.
// Assumes sutr_regs ports on ref_clk only.
`timescale 1ns/100ps
`include "sutr_consts.svh"
module sutr_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Power and line
    input wire logic processor_powered_flag,
    input wire logic suspend_active,
    input wire logic write_enable,
    input wire sutr_pkg::sutr_line_t line_mode,
    input wire logic line_dp,
    input wire logic line_dm,
    input wire logic force_fast_only,
    input wire logic force_full_only,
    input wire logic chirp_detect_en,
    input wire logic in_nak_only
);
    import sutr_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff rst;
    wire kw = reg_wr && reg_addr == `SUTR_OFS_UNLOCK;
    property p_lock;
        $rose(suspend_active) && !processor_powered_flag |=> !write_enable;
    endproperty
    a_lock: assert property (p_lock) else $error("no lock");
    property p_key;
        kw && reg_wdata == `SUTR_UNLOCK_KEY && !suspend_active |=> write_enable;
    endproperty
    a_key: assert property (p_key) else $error("key");
    property p_bad;
        kw && reg_wdata != `SUTR_UNLOCK_KEY && !write_enable |=> !write_enable;
    endproperty
    a_bad: assert property (p_bad) else $error("bad key");
    property p_chirp;
        force_fast_only || force_full_only |-> !chirp_detect_en;
    endproperty
    a_chirp: assert property (p_chirp) else $error("chirp");
    property p_stick;
        !$fell(force_fast_only) && !$fell(force_full_only) && !$fell(in_nak_only);
    endproperty
    a_stick: assert property (p_stick) else $error("left test");
    property p_k;
        line_mode == SUTR_LINE_K |=> line_dm && !line_dp;
    endproperty
    a_k: assert property (p_k) else $error("k level");
    property p_q;
        line_mode == SUTR_LINE_QUIET |-> in_nak_only ##1 !line_dp && !line_dm;
    endproperty
    a_q: assert property (p_q) else $error("quiet");
    property p_pseudo_random_line_test;
        line_mode == SUTR_LINE_PSEUDO_RANDOM_LINE_TEST |=> line_dm != line_dp;
    endproperty
    a_pseudo_random_line_test: assert property (p_pseudo_random_line_test) else $error("pattern");
    c_lock: cover property ($fell(write_enable));
    c_pseudo_random_line_test: cover property (line_mode == SUTR_LINE_PSEUDO_RANDOM_LINE_TEST);
    c_fast: cover property (force_fast_only);
endmodule : sutr_asserts
bind sutr_regs sutr_asserts chk (.*);

// ### sutr_line_host.sv
// Far-side line observer standing in for test equipment.
// Assumes line levels settle before each ref_clk edge.
`timescale 1ns/100ps
module sutr_line_host (
    // Clock and line
    input wire logic ref_clk,
    input wire logic line_dp,
    // Changes seen on the line
    output int flips
);
    logic dp_last = 1'h0;
    int flip_cnt = 0;
    always @(posedge ref_clk)
    begin
        if (line_dp !== dp_last)
            flip_cnt <= flip_cnt + 1;
        dp_last <= line_dp;
    end
    assign flips = flip_cnt;
endmodule : sutr_line_host

// ### scratch_unlock_usb_test_regs_tb_top.sv
// Self-checking bench for scratch, write lock and line test registers.
// Assumes sutr_regs and the line observer model.
`timescale 1ns/100ps
`include "sutr_consts.svh"
module scratch_unlock_usb_test_regs_tb_top;
    import sutr_pkg::*;
    logic ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic processor_powered_flag = 1'h0, suspend_active = 1'h0;
    logic write_enable, force_fast_only, force_full_only, line_dp, line_dm;
    logic chirp_detect_en, in_nak_only;
    sutr_line_t line_mode;
    int flips, error_cnt = 0, checks = 0;
    sutr_regs DUT (.*);
    sutr_line_host host (.*);
    always #12.5 ref_clk = ~ref_clk;
    task chk(input string nm, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'h1, a};
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 chk("rdata", reg_rdata, e);
    endtask : rd
    task conclude;
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task t_lock;
        wr(`SUTR_OFS_SCRATCH, 16'hA55A);
        rd(`SUTR_OFS_SCRATCH, 16'hA55A);
        rd(8'h90, 16'h0000);
        suspend_active <= 1'h1;
        wr(`SUTR_OFS_SCRATCH, 16'h5678);
        wr(`SUTR_OFS_UNLOCK, 16'hAA36);
        rd(`SUTR_OFS_SCRATCH, 16'hA55A);
        chk("wen", write_enable, 1'h0);
        wr(`SUTR_OFS_UNLOCK, `SUTR_UNLOCK_KEY);
        #1 chk("wen", write_enable, 1'h1);
        // Powered processor: a fresh suspend must not lock
        {processor_powered_flag, suspend_active} <= 2'h2;
        wr(`SUTR_OFS_TEST, 16'h0000);
        suspend_active <= 1'h1;
        wr(`SUTR_OFS_SCRATCH, 16'h0F0F);
        rd(`SUTR_OFS_SCRATCH, 16'h0F0F);
    endtask : t_lock
    task t_line;
        logic [7:0] code [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
        sutr_line_t md [4] = '{SUTR_LINE_QUIET, SUTR_LINE_J, SUTR_LINE_K,
            SUTR_LINE_PSEUDO_RANDOM_LINE_TEST};
        logic [1:0] lvl [3] = '{2'h0, 2'h2, 2'h1};
        int f0;
        // Reset between modes, as only a power cycle leaves a test mode
        for (int i = 0; i < 4; i++)
        begin
            rst <= 1'h1;
            repeat (2) @(posedge ref_clk);
            rst <= 1'h0;
            wr(`SUTR_OFS_TEST, {8'h00, code[i]});
            // Sticky copy follows one cycle, line levels one more
            @(posedge ref_clk);
            #1 chk("mode", line_mode, md[i]);
            chk("nak", in_nak_only, i == 0);
            @(posedge ref_clk);
            #1;
            if (i < 3)
                chk("dpdm", {line_dp, line_dm}, lvl[i]);
            wr(`SUTR_OFS_TEST, 16'h0000);
            rd(`SUTR_OFS_TEST, 16'h0000);
            chk("mode", line_mode, md[i]);
        end
        // Count only pattern-mode flips, not earlier J/K levels
        f0 = flips;
        repeat (40) @(posedge ref_clk);
        chk("flips", flips - f0 > 8, 1'h1);
        wr(`SUTR_OFS_TEST, 16'h00E0);
        rd(`SUTR_OFS_TEST, 16'h0080);
        chk("fast", {force_fast_only, chirp_detect_en}, 2'h2);
        chk("full", force_full_only, 1'h0);
        // Full-speed forcing needs its own power cycle
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        wr(`SUTR_OFS_TEST, 16'h0010);
        @(posedge ref_clk);
        #1 chk("full", {force_full_only, force_fast_only, chirp_detect_en},
            3'h4);
    endtask : t_line
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        t_lock();
        t_line();
        conclude();
    end
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        conclude();
    end
endmodule : scratch_unlock_usb_test_regs_tb_top
